// *** bise_params.svh ***
`ifndef BISE_PARAMS_SVH
`define BISE_PARAMS_SVH

// Register bus offsets
`define BISE_ADDR_CTRL      4'h0
`define BISE_ADDR_INSTR     4'h1
`define BISE_ADDR_WREG      4'h2
`define BISE_ADDR_STATUS    4'h3
`define BISE_ADDR_BANK      4'h4
`define BISE_ADDR_MEM_ADDR  4'h5
`define BISE_ADDR_MEM_DATA  4'h6
`define BISE_ADDR_STATE     4'h7

// Control fields
`define BISE_CTRL_EXT_BIT   0
`define BISE_CTRL_GO_BIT    1

// Status flag positions
`define BISE_FLAG_C         0
`define BISE_FLAG_DC        1
`define BISE_FLAG_Z         2
`define BISE_FLAG_OV        3
`define BISE_FLAG_N         4

// Opcode patterns
`define BISE_OPC_ADDC       6'h08
`define BISE_OPC_RLNC       6'h11
`define BISE_OPC_ANDL       8'h0B
`define BISE_OPC_MOVB       10'h004
`define BISE_OPC_LMOV       14'h0018
`define BISE_OPC_EXT_HI     4'hF

// Addressing
`define BISE_IDX_LIMIT      8'h5F
`define BISE_ACCESS_SPLIT   8'h60
`define BISE_ACCESS_HI_BANK 6'h3F
`define BISE_WREG_ADDR      14'h3FE8
`define BISE_FSR2_ADDR      14'h3FD9

// Reset values
`define BISE_RST_BYTE       8'h00
`define BISE_RST_BANK       6'h00

`endif

// *** bise_pkg.sv ***
package bise_pkg;
    typedef enum logic [2:0] {
        BISE_OP_NONE,
        BISE_OP_ADDC,
        BISE_OP_ANDL,
        BISE_OP_MOVB,
        BISE_OP_RLNC,
        BISE_OP_LMOV
    } bise_op_t;

    typedef struct packed {
        bise_op_t    op;
        logic        dest_file;
        logic        access_bsr;
        logic [7:0]  file_addr;
        logic [7:0]  literal;
    } bise_dec_t;

    typedef struct packed {
        logic        neg;
        logic        ovf;
        logic        zero;
        logic        dcarry;
        logic        carry;
    } bise_flags_t;
endpackage : bise_pkg

// *** bise_decode.sv ***
`timescale 1ns/1ns
`include "bise_params.svh"

module bise_decode (
    input  wire logic [15:0]        instr_i,
    output bise_pkg::bise_dec_t     dec_o
);
    import bise_pkg::*;

    always_comb begin
        dec_o            = '0;
        dec_o.dest_file  = instr_i[9];
        dec_o.access_bsr = instr_i[8];
        dec_o.file_addr  = instr_i[7:0];
        dec_o.literal    = instr_i[7:0];
        if (instr_i[15:10] == `BISE_OPC_ADDC) begin
            dec_o.op = BISE_OP_ADDC;
        end else if (instr_i[15:10] == `BISE_OPC_RLNC) begin
            dec_o.op = BISE_OP_RLNC;
        end else if (instr_i[15:8] == `BISE_OPC_ANDL) begin
            dec_o.op = BISE_OP_ANDL;
        end else if (instr_i[15:6] == `BISE_OPC_MOVB) begin
            dec_o.op      = BISE_OP_MOVB;
            dec_o.literal = {2'b00, instr_i[5:0]};
        end else if (instr_i[15:2] == `BISE_OPC_LMOV) begin
            dec_o.op = BISE_OP_LMOV;
        end
    end
endmodule : bise_decode

// *** bise_alu.sv ***
`timescale 1ns/1ns
`include "bise_params.svh"

module bise_alu (
    input  wire bise_pkg::bise_op_t    op_i,
    input  wire logic [7:0]            wreg_i,
    input  wire logic [7:0]            fval_i,
    input  wire logic [7:0]            lit_i,
    input  wire bise_pkg::bise_flags_t flags_i,
    output logic [7:0]                 res_o,
    output bise_pkg::bise_flags_t      flags_o
);
    import bise_pkg::*;

    logic [8:0] sum;
    logic [4:0] low_sum;

    always_comb begin
        sum     = {1'b0, wreg_i} + {1'b0, fval_i} + {8'h00, flags_i.carry};
        low_sum = {1'b0, wreg_i[3:0]} + {1'b0, fval_i[3:0]} + {4'h0, flags_i.carry};
        res_o   = fval_i;
        flags_o = flags_i;
        unique case (op_i)
            BISE_OP_ADDC: begin
                res_o          = sum[7:0];
                flags_o.carry  = sum[8];
                flags_o.dcarry = low_sum[4];
                flags_o.ovf    = (wreg_i[7] == fval_i[7]) && (sum[7] != wreg_i[7]);
                flags_o.neg    = sum[7];
                flags_o.zero   = (sum[7:0] == 8'h00);
            end
            BISE_OP_ANDL: begin
                res_o        = wreg_i & lit_i;
                flags_o.neg  = res_o[7];
                flags_o.zero = (res_o == 8'h00);
            end
            BISE_OP_RLNC: begin
                res_o        = {fval_i[6:0], fval_i[7]};
                flags_o.neg  = res_o[7];
                flags_o.zero = (res_o == 8'h00);
            end
            BISE_OP_LMOV,
            BISE_OP_MOVB,
            BISE_OP_NONE: begin
                res_o = fval_i;
            end
            default: begin
                res_o = fval_i;
            end
        endcase
    end
endmodule : bise_alu

// *** bise_core.sv ***
`timescale 1ns/1ns
`include "bise_params.svh"

module bise_core (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [15:0]      rdata_o,
    output logic             busy_o
);
    import bise_pkg::*;

    typedef enum logic [1:0] {
        BISE_ST_IDLE,
        BISE_ST_WORD2,
        BISE_ST_WORD3
    } bise_state_t;

    // Data space, 16 Kbyte
    logic [7:0]  data_mem [0:16383];

    bise_state_t state, next_state;
    logic [15:0] instr, next_instr;
    logic [7:0]  wreg, next_wreg;
    bise_flags_t flags, next_flags;
    logic [5:0]  bank_select_reg, next_bank_select_reg;
    logic        ext_en, next_ext_en;
    logic [13:0] mem_addr, next_mem_addr;
    logic [13:0] src_addr, next_src_addr;
    logic [15:0] rdata, next_rdata;
    logic        busy, next_busy;

    bise_dec_t   dec;
    bise_flags_t alu_flags;
    logic [7:0]  alu_res;
    logic [7:0]  fval;
    logic [13:0] eff_addr;
    logic [7:0]  fsr2_lo;
    logic [7:0]  fsr2_hi;
    logic [13:0] fsr2;
    logic        mem_we;
    logic [13:0] mem_wa;
    logic [7:0]  mem_wd;
    logic [7:0]  src_val;

    bise_decode u_decode (
        .instr_i (instr),
        .dec_o   (dec)
    );

    bise_alu u_alu (
        .op_i    (dec.op),
        .wreg_i  (wreg),
        .fval_i  (fval),
        .lit_i   (dec.literal),
        .flags_i (flags),
        .res_o   (alu_res),
        .flags_o (alu_flags)
    );

    assign fsr2_lo = data_mem[`BISE_FSR2_ADDR];
    assign fsr2_hi = data_mem[`BISE_FSR2_ADDR + 14'h0001];
    assign fsr2    = {fsr2_hi[5:0], fsr2_lo};

    // Operand address resolution
    always_comb begin
        if (dec.access_bsr) begin
            eff_addr = {bank_select_reg, dec.file_addr};
        end else if (ext_en && (dec.file_addr <= `BISE_IDX_LIMIT)) begin
            eff_addr = fsr2 + {6'h00, dec.file_addr};
        end else if (dec.file_addr < `BISE_ACCESS_SPLIT) begin
            eff_addr = {6'h00, dec.file_addr};
        end else begin
            eff_addr = {`BISE_ACCESS_HI_BANK, dec.file_addr};
        end
    end

    // W reachable as long move source
    assign src_val = (src_addr == `BISE_WREG_ADDR) ? wreg : data_mem[src_addr];
    assign fval    = (eff_addr == `BISE_WREG_ADDR) ? wreg : data_mem[eff_addr];

    always_comb begin
        next_state           = state;
        next_instr           = instr;
        next_wreg            = wreg;
        next_flags           = flags;
        next_bank_select_reg = bank_select_reg;
        next_ext_en          = ext_en;
        next_mem_addr        = mem_addr;
        next_src_addr        = src_addr;
        next_rdata           = rdata;
        next_busy            = busy;
        mem_we               = 1'b0;
        mem_wa               = mem_addr;
        mem_wd               = wdata_i[7:0];

        if (rd_i) begin
            unique case (addr_i)
                `BISE_ADDR_CTRL:     next_rdata = {15'h0000, ext_en};
                `BISE_ADDR_INSTR:    next_rdata = instr;
                `BISE_ADDR_WREG:     next_rdata = {8'h00, wreg};
                `BISE_ADDR_STATUS:   next_rdata = {11'h000, flags.neg, flags.ovf, flags.zero,
                                                   flags.dcarry, flags.carry};
                `BISE_ADDR_BANK:     next_rdata = {10'h000, bank_select_reg};
                `BISE_ADDR_MEM_ADDR: next_rdata = {2'b00, mem_addr};
                `BISE_ADDR_MEM_DATA: next_rdata = {8'h00, data_mem[mem_addr]};
                `BISE_ADDR_STATE:    next_rdata = {15'h0000, busy};
                default:             next_rdata = 16'h0000;
            endcase
        end

        unique case (state)
            BISE_ST_IDLE: begin
                next_busy = 1'b0;
                if (wr_i) begin
                    unique case (addr_i)
                        `BISE_ADDR_CTRL:     next_ext_en = wdata_i[`BISE_CTRL_EXT_BIT];
                        `BISE_ADDR_INSTR: begin
                            next_instr = wdata_i;
                            if (wdata_i[15:2] == `BISE_OPC_LMOV) begin
                                next_state = BISE_ST_WORD2;
                                next_busy  = 1'b1;
                            end
                        end
                        `BISE_ADDR_WREG:     next_wreg = wdata_i[7:0];
                        `BISE_ADDR_STATUS: begin
                            next_flags.carry  = wdata_i[`BISE_FLAG_C];
                            next_flags.dcarry = wdata_i[`BISE_FLAG_DC];
                            next_flags.zero   = wdata_i[`BISE_FLAG_Z];
                            next_flags.ovf    = wdata_i[`BISE_FLAG_OV];
                            next_flags.neg    = wdata_i[`BISE_FLAG_N];
                        end
                        `BISE_ADDR_BANK:     next_bank_select_reg = wdata_i[5:0];
                        `BISE_ADDR_MEM_ADDR: next_mem_addr = wdata_i[13:0];
                        `BISE_ADDR_MEM_DATA: mem_we = 1'b1;
                        default: begin
                        end
                    endcase
                    // Execute on go strobe of control register
                    if (addr_i == `BISE_ADDR_CTRL && wdata_i[`BISE_CTRL_GO_BIT]) begin
                        unique case (dec.op)
                            BISE_OP_ADDC,
                            BISE_OP_RLNC: begin
                                next_flags = alu_flags;
                                if (dec.dest_file) begin
                                    if (eff_addr == `BISE_WREG_ADDR) begin
                                        next_wreg = alu_res;
                                    end else begin
                                        mem_we = 1'b1;
                                        mem_wa = eff_addr;
                                        mem_wd = alu_res;
                                    end
                                end else begin
                                    next_wreg = alu_res;
                                end
                            end
                            BISE_OP_ANDL: begin
                                next_wreg  = alu_res;
                                next_flags = alu_flags;
                            end
                            BISE_OP_MOVB: begin
                                next_bank_select_reg = dec.literal[5:0];
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            BISE_ST_WORD2: begin
                if (wr_i && addr_i == `BISE_ADDR_INSTR) begin
                    // 14-bit source from words one and two
                    next_src_addr = {instr[1:0], wdata_i[11:0]};
                    next_state    = (wdata_i[15:12] == `BISE_OPC_EXT_HI) ? BISE_ST_WORD3 : BISE_ST_IDLE;
                    next_busy     = (wdata_i[15:12] == `BISE_OPC_EXT_HI);
                end
            end
            BISE_ST_WORD3: begin
                if (wr_i && addr_i == `BISE_ADDR_INSTR) begin
                    next_state = BISE_ST_IDLE;
                    next_busy  = 1'b0;
                    if (wdata_i[13:0] == `BISE_WREG_ADDR) begin
                        next_wreg = src_val;
                    end else begin
                        mem_we = 1'b1;
                        mem_wa = wdata_i[13:0];
                        mem_wd = src_val;
                    end
                end
            end
            default: begin
                next_state = BISE_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            data_mem[mem_wa] <= mem_wd;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state           <= BISE_ST_IDLE;
            instr           <= 16'h0000;
            wreg            <= `BISE_RST_BYTE;
            flags           <= '0;
            bank_select_reg <= `BISE_RST_BANK;
            ext_en          <= 1'b0;
            mem_addr        <= 14'h0000;
            src_addr        <= 14'h0000;
            rdata           <= 16'h0000;
            busy            <= 1'b0;
        end else begin
            state           <= next_state;
            instr           <= next_instr;
            wreg            <= next_wreg;
            flags           <= next_flags;
            bank_select_reg <= next_bank_select_reg;
            ext_en          <= next_ext_en;
            mem_addr        <= next_mem_addr;
            src_addr        <= next_src_addr;
            rdata           <= next_rdata;
            busy            <= next_busy;
        end
    end

    assign rdata_o = rdata;
    assign busy_o  = busy;
endmodule : bise_core

// *** bise_core_props.sv ***
`timescale 1ns/1ns
module bise_core_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [3:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic        busy_o
);
    logic [1:0] phase;
    logic [1:0] next_phase;
    logic       instr_wr;
    logic       lm_first;

    assign instr_wr = wr_i && addr_i == 4'h1;
    assign lm_first = instr_wr && wdata_i[15:2] == 14'h0018;

    // Which long-move word the port expects next
    always_comb begin
        next_phase = phase;
        if (instr_wr) begin
            if (phase == 2'h0 && lm_first) begin
                next_phase = 2'h1;
            end else if (phase == 2'h1 && wdata_i[15:12] == 4'hF) begin
                next_phase = 2'h2;
            end else begin
                next_phase = 2'h0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase <= 2'h0;
        end else begin
            phase <= next_phase;
        end
    end

    function automatic logic [1:0] nz8(input logic [15:0] v);
        return {v[7], v[7:0] == 8'h00};
    endfunction : nz8

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence go_s;
        wr_i && addr_i == 4'h0 && wdata_i[1];
    endsequence
    sequence bank_load_s;
        !busy_o && instr_wr && wdata_i[15:6] == 10'h004 ##1 go_s;
    endsequence
    sequence and_s;
        !busy_o && wr_i && addr_i == 4'h2 ##1 instr_wr && wdata_i[15:8] == 8'h0B ##1 go_s;
    endsequence

    lmov_enter_a: assert property (phase == 2'h0 && lm_first |=> busy_o)
        else $error("long move did not raise busy");
    lmov_abort_a: assert property (phase == 2'h1 && instr_wr && wdata_i[15:12] != 4'hF |=> !busy_o)
        else $error("bad second word did not abort");
    lmov_wait_a: assert property (phase == 2'h1 && instr_wr && wdata_i[15:12] == 4'hF |=> busy_o)
        else $error("busy dropped before third word");
    lmov_done_a: assert property (phase == 2'h2 && instr_wr |=> !busy_o)
        else $error("busy stayed after third word");
    busy_hold_a: assert property (busy_o && !instr_wr |=> busy_o)
        else $error("busy dropped without instruction word");
    idle_busy_a: assert property (phase == 2'h0 && !lm_first |=> !busy_o)
        else $error("busy raised without long move");
    state_read_a: assert property (rd_i && addr_i == 4'h7 |=> rdata_o[0] == $past(busy_o))
        else $error("state read differs from busy");
    bank_load_a: assert property (bank_load_s ##1 (rd_i && addr_i == 4'h4)
        |=> rdata_o[5:0] == 6'($past(wdata_i, 3)))
        else $error("bank select not loaded");
    and_result_a: assert property (and_s ##1 (rd_i && addr_i == 4'h2)
        |=> rdata_o[7:0] == 8'($past(wdata_i, 4) & $past(wdata_i, 3)))
        else $error("and literal result wrong");
    and_flags_a: assert property (and_s ##1 (rd_i && addr_i == 4'h2) ##2 (rd_i && addr_i == 4'h3)
        |=> {rdata_o[4], rdata_o[2]} == nz8($past(wdata_i, 6) & $past(wdata_i, 5)))
        else $error("and literal flags wrong");
endmodule : bise_core_props

bind bise_core bise_core_props bise_core_props_i (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .addr_i  (addr_i),
    .wdata_i (wdata_i),
    .wr_i    (wr_i),
    .rd_i    (rd_i),
    .rdata_o (rdata_o),
    .busy_o  (busy_o)
);

// *** bise_core_bench.sv ***
`timescale 1ns/1ns
module bise_core_bench;
    import bise_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [3:0]  addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [15:0] rdata_o;
    logic        busy_o;
    int          err_count = 0;
    int          compares = 0;
    logic [7:0]  w;
    logic [5:0]  bank;
    logic [13:0] fsr2;
    logic        ext;
    bise_flags_t fl;

    always #10 clk_i = ~clk_i;

    bise_core bise_core_i (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .addr_i  (addr_i),
        .wdata_i (wdata_i),
        .wr_i    (wr_i),
        .rd_i    (rd_i),
        .rdata_o (rdata_o),
        .busy_o  (busy_o)
    );

    task automatic end_sim();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic ws, input logic rs, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i    <= ws;
        rd_i    <= rs;
        addr_i  <= a;
        wdata_i <= d;
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask : wr

    // Idle cycle after each read keeps the answer cycle clean
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        bus(1'b0, 1'b1, a, 16'h0000);
        bus(1'b0, 1'b0, 4'h0, 16'h0000);
        #1 d = rdata_o;
    endtask : rd

    // W lives at 3FE8h in data space, reached through its own index
    task automatic put(input logic [13:0] ad, input logic [7:0] v);
        if (ad == 14'h3FE8) begin
            wr(4'h2, {8'h00, v});
            w = v;
        end else begin
            wr(4'h5, {2'b00, ad});
            wr(4'h6, {8'h00, v});
        end
    endtask : put

    task automatic get(input logic [13:0] ad, output logic [15:0] d);
        if (ad != 14'h3FE8) begin
            wr(4'h5, {2'b00, ad});
        end
        rd(ad == 14'h3FE8 ? 4'h2 : 4'h6, d);
    endtask : get

    function automatic logic [13:0] faddr(input logic a, input logic [7:0] f);
        if (a) begin
            return {bank, f};
        end
        if (ext && f <= 8'h5F) begin
            return fsr2 + 14'(f);
        end
        return f < 8'h60 ? {6'h00, f} : {6'h3F, f};
    endfunction : faddr

    task automatic movb(input logic [5:0] k);
        logic [15:0] got;
        bank = k;
        wr(4'h1, {10'h004, k});
        wr(4'h0, {14'h0000, 1'b1, ext});
        rd(4'h4, got);
        chk(got, {10'h000, k});
        rd(4'h3, got);
        chk(got, {11'h000, fl});
    endtask : movb

    // kind 0 add with carry, 1 rotate left, 2 and literal (f is the literal)
    task automatic run_op(input int kind, input logic d, input logic a, input logic [7:0] f);
        logic [13:0] ad;
        logic [7:0]  fv;
        logic [7:0]  res;
        logic [8:0]  s;
        logic [15:0] ins;
        logic [15:0] got;
        ad = faddr(a, f);
        // Execute uses the mode already held, not the one written with go
        wr(4'h0, {15'h0000, ext});
        fv = 8'($urandom);
        put(ad, fv);
        w = 8'($urandom);
        wr(4'h2, {8'h00, w});
        if (kind == 0) begin
            s = 9'(w) + 9'(fv) + 9'(fl.carry);
            fl.dcarry = (5'(w[3:0]) + 5'(fv[3:0]) + 5'(fl.carry)) > 5'h0F;
            fl.ovf = (w[7] == fv[7]) && (s[7] != w[7]);
            fl.carry = s[8];
            res = s[7:0];
            ins = {6'h08, d, a, f};
        end else if (kind == 1) begin
            res = {fv[6:0], fv[7]};
            ins = {6'h11, d, a, f};
        end else begin
            res = w & f;
            ins = {8'h0B, f};
        end
        fl.neg = res[7];
        fl.zero = res == 8'h00;
        wr(4'h1, ins);
        wr(4'h0, {14'h0000, 1'b1, ext});
        if (d && kind != 2) begin
            fv = res;
        end else begin
            w = res;
        end
        rd(4'h2, got);
        chk(got, {8'h00, w});
        rd(4'h3, got);
        chk(got, {11'h000, fl});
        get(ad, got);
        chk(got, {8'h00, fv});
    endtask : run_op

    task automatic lmov(input logic [13:0] sa, input logic [13:0] da, input logic abort);
        logic [7:0]  v;
        logic [15:0] got;
        v = 8'($urandom);
        put(da, ~v);
        put(sa, v);
        wr(4'h1, {14'h0018, sa[13:12]});
        // Must be ignored while the move waits
        wr(4'h2, 16'h00AA);
        rd(4'h7, got);
        chk(got, 16'h0001);
        chk({15'h0000, busy_o}, 16'h0001);
        wr(4'h1, abort ? 16'h0000 : {4'hF, sa[11:0]});
        if (!abort) begin
            wr(4'h1, {2'b11, da});
        end
        rd(4'h7, got);
        chk(got, 16'h0000);
        if (da == 14'h3FE8 && !abort) begin
            w = v;
        end
        get(da, got);
        chk(got, {8'h00, abort ? ~v : v});
        rd(4'h3, got);
        chk(got, {11'h000, fl});
    endtask : lmov

    initial begin
        #200000;
        err_count++;
        end_sim();
    end

    initial begin
        logic [15:0] got;
        logic        a;
        w = 8'($urandom(86826));
        w = 8'h00;
        fl = '0;
        bank = 6'h00;
        ext = 1'b0;
        fsr2 = 14'h0200;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        // Data memory has no reset value
        put(14'h0000, 8'h00);
        for (int i = 2; i <= 7; i++) begin
            rd(4'(i), got);
            chk(got, 16'h0000);
        end
        wr(4'hC, 16'hFFFF);
        rd(4'hC, got);
        chk(got, 16'h0000);
        put(14'h3FD9, 8'h00);
        put(14'h3FDA, 8'h02);
        movb(6'h3E);
        run_op(2, 1'b0, 1'b0, 8'h5F);
        run_op(1, 1'b1, 1'b0, 8'h60);
        run_op(0, 1'b1, 1'b1, 8'hFF);
        ext = 1'b1;
        run_op(0, 1'b1, 1'b0, 8'h5F);
        run_op(1, 1'b0, 1'b0, 8'h60);
        ext = 1'b0;
        lmov(14'h3FFF, 14'h0000, 1'b0);
        lmov(14'h3FE8, 14'h0123, 1'b0);
        lmov(14'h0456, 14'h3FE8, 1'b0);
        lmov(14'h0789, 14'h0ABC, 1'b1);
        repeat (40) begin
            ext = 1'($urandom_range(1));
            movb(6'($urandom_range(62)));
            a = 1'($urandom_range(1));
            run_op(int'($urandom_range(2)), 1'($urandom_range(1)), a,
                   a ? 8'($urandom) : 8'($urandom_range(95)));
        end
        lmov(14'($urandom_range(4095)), 14'h1000 + 14'($urandom_range(4095)), 1'b0);
        end_sim();
    end
endmodule : bise_core_bench
